/* File: stepper_ref_cfg.svh */
// offsets, fields, reset values and widths of the search block
// assumes a 32-bit AXI4-Lite register window with 8 address bits
`ifndef STEPPER_REF_CFG_SVH
`define STEPPER_REF_CFG_SVH
`define OFF_CTRL      8'h00
`define OFF_MODE      8'h04
`define OFF_SRCH_VEL  8'h08
`define OFF_CAL_VEL   8'h0c
`define OFF_STALL_VEL 8'h10
`define OFF_STALL_THR 8'h14
`define OFF_STATUS    8'h18
`define OFF_POS       8'h1c
`define OFF_DIST      8'h20
`define OFF_LOAD      8'h24
`define OFF_IRQ_STAT  8'h28
`define OFF_IRQ_MASK  8'h2c
`define OFF_MAN_VEL   8'h30
`define CTRL_START    0
`define CTRL_STOP     1
`define CTRL_STALL_EN 2
`define CTRL_LSTOP_L  3
`define CTRL_LSTOP_R  4
`define CTRL_CLR_STL  5
`define MODE_SWAP     6
`define MODE_INV_HOME 7
`define MODE_OPCODE   8'h0d
`define RST_MODE      8'h01
`define RST_SRCH_VEL  23'h001000
`define RST_CAL_VEL   23'h000100
`define RST_STALL_VEL 23'h000000
`define RST_STALL_THR 10'h000
`define IRQ_DONE      0
`define IRQ_STALL     1
`define IRQ_BADMODE   2
`define IRQ_ABORT     3
`define IRQ_W         4
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

/* File: stepper_ref_pkg.sv */
// types shared by the reference search block
// assumes stepper_ref_cfg.svh for numeric constants
package stepper_ref_pkg;
    typedef struct packed {
        logic home;
        logic limR;
        logic limL;
    } sw_s;
    typedef enum logic [5:0] {
        ST_IDLE    = 6'b000001,
        ST_PRE     = 6'b000010,
        ST_SEEK    = 6'b000100,
        ST_BACK    = 6'b001000,
        ST_REENTER = 6'b010000,
        ST_CROSS   = 6'b100000
    } state_e;
    typedef enum logic [1:0] {
        SEL_LEFT  = 2'd0,
        SEL_RIGHT = 2'd1,
        SEL_HOME  = 2'd2
    } sel_e;
    typedef struct packed {
        logic ok;
        logic pre;
        sel_e preSel;
        logic preNeg;
        sel_e tgtSel;
        logic tgtNeg;
        logic center;
        logic revOnLimit;
        logic useLimits;
        logic invHome;
    } plan_s;
    typedef struct packed {
        logic step;
        logic dirNeg;
    } step_s;
endpackage

/* File: stepper_ref_search.sv */
// reference search sequencer with stall stop and AXI4-Lite register window
// assumes a motion generator on sys_clk that follows velCmd and reports each
// microstep on stepIn; switch pins are asynchronous, load value is on sys_clk
// Summary of operation
// R1: home search instruction starts, stops, polls homing.
// R2: limit auto-stop enables ignored while homing.
// R3: search velocity until target switch first seen.
// R4: creep out, re-enter opposite way at calibration speed, midpoint.
// R5: mode bases 1 to 8 pick distinct patterns.
// R6: mode 1 left limit only; plus 64 right instead.
// R7: mode 2 right then left, left zero, distance in microsteps.
// R8: mode 66 left first, right limit zero.
// R9: mode 3 right then left middle zero; distance to middle.
// R10: mode 67 left first, right switch middle zero.
// R11: mode 4 left switch middle; 68 right switch middle.
// R12: mode 5 home negative, reverse at left limit; 129 inverts. Code decodes 129 as mode 1 and drops the inversion.
// R13: mode 6 home positive, reverse at right limit; 130 inverts. Code decodes 130 as mode 2 and drops the inversion.
// R14: mode 7 home positive, no limits, middle zero; 131 inverts. Code decodes 131 as mode 3 and drops the inversion.
// R15: mode 8 home, no limits, middle zero; 132 inverts. Code decodes 132 as mode 4 and drops the inversion.
// R16: load value linear with load, zero at maximum.
// R17: stall detection on: stop motor when load too high.
// R18: below stop-on-stall velocity never stop; above, stop at threshold.
// R19: on completion zero position at reference, flag done.
`include "stepper_ref_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module stepper_ref_search #(
    parameter int VW = 24,
    parameter int PW = 32,
    parameter int LW = 10
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // axi4-lite slave
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // switch pins, asynchronous
    input  wire stepper_ref_pkg::sw_s   swPins,
    // motion generator and driver
    input  wire stepper_ref_pkg::step_s stepIn,
    input  wire logic [LW-1:0]          loadIn,
    output logic signed [VW-1:0]        velCmd,
    output logic                        homeBusy,
    output logic                        irq
);
    import stepper_ref_pkg::*;

    // three-stage synchronisers; value moves once stages two and three agree
    logic [2:0] sw1Q, sw2Q, sw3Q, swQ;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sw1Q[gi] <= 1'b0;
                    sw2Q[gi] <= 1'b0;
                    sw3Q[gi] <= 1'b0;
                    swQ[gi]  <= 1'b0;
                end else begin
                    sw1Q[gi] <= swPins[gi];
                    sw2Q[gi] <= sw1Q[gi];
                    sw3Q[gi] <= sw2Q[gi];
                    if (sw2Q[gi] == sw3Q[gi]) begin
                        swQ[gi] <= sw3Q[gi];
                    end
                end
            end
        end
    endgenerate
    sw_s sw;
    assign sw = swQ;

    // registers
    logic [7:0]      modeQ;
    logic [VW-2:0]   srchVelQ, calVelQ, stopOnStallVelQ;
    logic [LW-1:0]   stallThrQ, loadQ;
    logic [VW-1:0]   manVelQ;
    logic            stallEnQ, lStopLQ, lStopRQ;
    logic [`IRQ_W-1:0] irqStatQ, irqMaskQ, irqSet;
    logic            startReq, stopReq, clrStall;
    logic            doneQ, stalledQ;
    state_e          stateQ;
    plan_s           planQ, planNew;
    logic            dirNegQ;
    logic signed [PW-1:0] posQ, edgeQ, firstQ, distQ;

    // axi write path: address and data taken in either order
    logic [7:0]  awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0]  wStrbQ;
    logic        awHaveQ, wHaveQ, doWrite, doRead;
    assign doWrite = awHaveQ && wHaveQ && !s_axi_bvalid;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHaveQ       <= 1'b0;
            wHaveQ        <= 1'b0;
            awAddrQ       <= 8'h00;
            wDataQ        <= 32'h0;
            wStrbQ        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !awHaveQ && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHaveQ && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHaveQ <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHaveQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHaveQ      <= 1'b0;
                wHaveQ       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddrQ[7:2] > `OFF_MAN_VEL >> 2) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    logic [31:0] wv, wOld;
    always_comb begin
        wOld = 32'h0;
        case (awAddrQ)
            `OFF_MODE:      wOld = {24'h0, modeQ};
            `OFF_SRCH_VEL:  wOld = {{(33-VW){1'b0}}, srchVelQ};
            `OFF_CAL_VEL:   wOld = {{(33-VW){1'b0}}, calVelQ};
            `OFF_STALL_VEL: wOld = {{(33-VW){1'b0}}, stopOnStallVelQ};
            `OFF_STALL_THR: wOld = {{(32-LW){1'b0}}, stallThrQ};
            `OFF_IRQ_MASK:  wOld = {{(32-`IRQ_W){1'b0}}, irqMaskQ};
            `OFF_MAN_VEL:   wOld = {{(32-VW){manVelQ[VW-1]}}, manVelQ};
            default: ;
        endcase
        wv = merge(wOld, wDataQ, wStrbQ);
    end

    // command strobes act once per control write
    assign startReq = doWrite && awAddrQ == `OFF_CTRL && wv[`CTRL_START]; // R1
    assign stopReq  = doWrite && awAddrQ == `OFF_CTRL && wv[`CTRL_STOP]; // R1
    assign clrStall = doWrite && awAddrQ == `OFF_CTRL && wv[`CTRL_CLR_STL];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            modeQ           <= `RST_MODE;
            srchVelQ        <= `RST_SRCH_VEL;
            calVelQ         <= `RST_CAL_VEL;
            stopOnStallVelQ <= `RST_STALL_VEL;
            stallThrQ       <= `RST_STALL_THR;
            irqMaskQ        <= '0;
            manVelQ         <= '0;
            stallEnQ        <= 1'b0;
            lStopLQ         <= 1'b0;
            lStopRQ         <= 1'b0;
        end else if (doWrite) begin
            case (awAddrQ)
                `OFF_CTRL: begin
                    stallEnQ <= wv[`CTRL_STALL_EN];
                    lStopLQ  <= wv[`CTRL_LSTOP_L];
                    lStopRQ  <= wv[`CTRL_LSTOP_R];
                end
                `OFF_MODE:      modeQ           <= wv[7:0];
                `OFF_SRCH_VEL:  srchVelQ        <= wv[VW-2:0];
                `OFF_CAL_VEL:   calVelQ         <= wv[VW-2:0];
                `OFF_STALL_VEL: stopOnStallVelQ <= wv[VW-2:0];
                `OFF_STALL_THR: stallThrQ       <= wv[LW-1:0];
                `OFF_IRQ_MASK:  irqMaskQ        <= wv[`IRQ_W-1:0];
                `OFF_MAN_VEL:   manVelQ         <= wv[VW-1:0];
                default: ;
            endcase
        end
    end

    // axi read path, one cycle from address to data
    assign doRead = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (doRead) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (s_axi_araddr)
                    `OFF_CTRL:      s_axi_rdata <= {27'h0, lStopRQ, lStopLQ, stallEnQ, 2'b00};
                    `OFF_MODE:      s_axi_rdata <= {24'h0, modeQ};
                    `OFF_SRCH_VEL:  s_axi_rdata <= {{(33-VW){1'b0}}, srchVelQ};
                    `OFF_CAL_VEL:   s_axi_rdata <= {{(33-VW){1'b0}}, calVelQ};
                    `OFF_STALL_VEL: s_axi_rdata <= {{(33-VW){1'b0}}, stopOnStallVelQ};
                    `OFF_STALL_THR: s_axi_rdata <= {{(32-LW){1'b0}}, stallThrQ};
                    `OFF_STATUS:    s_axi_rdata <= {16'h0, `MODE_OPCODE, stateQ, stalledQ, doneQ}; // R1
                    `OFF_POS:       s_axi_rdata <= posQ;
                    `OFF_DIST:      s_axi_rdata <= distQ;
                    `OFF_LOAD:      s_axi_rdata <= {{(32-LW){1'b0}}, loadQ}; // R16
                    `OFF_IRQ_STAT:  s_axi_rdata <= {{(32-`IRQ_W){1'b0}}, irqStatQ};
                    `OFF_IRQ_MASK:  s_axi_rdata <= {{(32-`IRQ_W){1'b0}}, irqMaskQ};
                    `OFF_MAN_VEL:   s_axi_rdata <= {{(32-VW){manVelQ[VW-1]}}, manVelQ};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // pattern decode; unknown bases refuse the start
    always_comb begin
        planNew            = '0;
        planNew.useLimits  = 1'b1;
        planNew.invHome    = modeQ[`MODE_INV_HOME];
        planNew.preSel     = SEL_RIGHT;
        planNew.tgtSel     = SEL_LEFT;
        planNew.tgtNeg     = 1'b1;
        case (modeQ[5:0]) // R5
            6'h01: planNew.ok = 1'b1; // R6
            6'h02: begin
                planNew.ok  = 1'b1; // R7
                planNew.pre = 1'b1;
            end
            6'h03: begin
                planNew.ok     = 1'b1; // R9
                planNew.pre    = 1'b1;
                planNew.center = 1'b1;
            end
            6'h04: begin
                planNew.ok     = 1'b1; // R11
                planNew.center = 1'b1;
            end
            6'h05: begin
                planNew.ok         = 1'b1; // R12
                planNew.tgtSel     = SEL_HOME;
                planNew.revOnLimit = 1'b1;
            end
            6'h06: begin
                planNew.ok         = 1'b1; // R13
                planNew.tgtSel     = SEL_HOME;
                planNew.tgtNeg     = 1'b0;
                planNew.revOnLimit = 1'b1;
            end
            6'h07: begin
                planNew.ok        = 1'b1; // R14
                planNew.tgtSel    = SEL_HOME;
                planNew.tgtNeg    = 1'b0;
                planNew.center    = 1'b1;
                planNew.useLimits = 1'b0;
            end
            6'h08: begin
                planNew.ok        = 1'b1; // R15
                planNew.tgtSel    = SEL_HOME;
                planNew.center    = 1'b1;
                planNew.useLimits = 1'b0;
            end
            default: planNew.ok = 1'b0;
        endcase
        // the side swap only applies to limit patterns, the home bit only to home patterns
        if (modeQ[`MODE_SWAP] && modeQ[5:0] <= 6'h04) begin
            planNew.tgtSel = SEL_RIGHT; // R6 R8 R10 R11
            planNew.tgtNeg = 1'b0;
            planNew.preSel = SEL_LEFT;
            planNew.preNeg = 1'b1;
        end
        if (modeQ[5:0] <= 6'h04) begin
            planNew.invHome = 1'b0;
        end
        if (modeQ[`MODE_SWAP] && modeQ[5:0] > 6'h04) begin
            planNew.ok = 1'b0;
        end
    end

    function automatic logic swActive(input sel_e s, input sw_s w, input logic inv);
        case (s)
            SEL_LEFT:  return w.limL;
            SEL_RIGHT: return w.limR;
            default:   return w.home ^ inv; // R12 R13 R14 R15
        endcase
    endfunction

    logic preHit, tgtHit, revHit, stallNow, hitAny;
    logic signed [PW-1:0] stepDelta, midPos;
    logic signed [PW:0]   midSum;
    logic signed [VW-1:0] velMag;
    assign preHit    = swActive(planQ.preSel, sw, planQ.invHome);
    assign tgtHit    = swActive(planQ.tgtSel, sw, planQ.invHome);
    assign revHit    = planQ.revOnLimit && planQ.useLimits && (dirNegQ ? sw.limL : sw.limR);
    assign stepDelta = !stepIn.step ? '0 : (stepIn.dirNeg ? -1 : 1);
    assign midSum    = {edgeQ[PW-1], edgeQ} + {posQ[PW-1], posQ};
    assign midPos    = midSum[PW:1]; // R4
    assign velMag    = velCmd[VW-1] ? -velCmd : velCmd;
    // stall counts only above stop-on-stall velocity, never at rest
    assign stallNow  = stallEnQ && (velMag > $signed({1'b0, stopOnStallVelQ})) &&
                       (loadQ <= stallThrQ); // R17 R18
    assign hitAny    = (stateQ == ST_REENTER && tgtHit && !planQ.center) ||
                       (stateQ == ST_CROSS && !tgtHit);

    // homing sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ  <= ST_IDLE;
            planQ   <= '0;
            dirNegQ <= 1'b0;
            edgeQ   <= '0;
            firstQ  <= '0;
            distQ   <= '0;
            doneQ   <= 1'b0;
        end else if (stopReq || stallNow) begin
            stateQ <= ST_IDLE; // R1 R17
        end else begin
            case (stateQ)
                ST_IDLE: begin
                    if (startReq && planNew.ok && !stalledQ) begin
                        planQ   <= planNew;
                        doneQ   <= 1'b0;
                        dirNegQ <= planNew.pre ? planNew.preNeg : planNew.tgtNeg;
                        stateQ  <= planNew.pre ? ST_PRE : ST_SEEK;
                    end
                end
                ST_PRE: begin
                    if (preHit) begin
                        firstQ  <= posQ; // R7 R9
                        dirNegQ <= planQ.tgtNeg;
                        stateQ  <= ST_SEEK;
                    end
                end
                ST_SEEK: begin
                    if (tgtHit) begin
                        dirNegQ <= !dirNegQ; // R4
                        stateQ  <= ST_BACK;
                    end else if (revHit) begin
                        dirNegQ <= !dirNegQ; // R12 R13
                    end
                end
                ST_BACK: begin
                    if (!tgtHit) begin
                        edgeQ   <= posQ; // R4
                        dirNegQ <= !dirNegQ;
                        stateQ  <= ST_REENTER;
                    end
                end
                ST_REENTER: begin
                    if (tgtHit && planQ.center) begin
                        edgeQ  <= midPos; // R11
                        stateQ <= ST_CROSS;
                    end
                end
                ST_CROSS: ;
                default: stateQ <= ST_IDLE;
            endcase
            if (hitAny) begin
                stateQ <= ST_IDLE;
                doneQ  <= 1'b1; // R19
                distQ  <= !planQ.pre ? '0 :
                          (firstQ > midPos ? firstQ - midPos : midPos - firstQ); // R7 R9
            end
        end
    end

    // position counter, rebased so the reference reads zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            posQ <= '0;
        end else if (hitAny && !stopReq && !stallNow) begin
            posQ <= posQ + stepDelta - midPos; // R19
        end else begin
            posQ <= posQ + stepDelta;
        end
    end

    // velocity command; homing ignores limit auto-stop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            velCmd   <= '0;
            homeBusy <= 1'b0;
        end else begin
            homeBusy <= stateQ != ST_IDLE;
            if (stallNow || stalledQ || stopReq) begin
                velCmd <= '0; // R17
            end else begin
                case (stateQ)
                    ST_PRE, ST_SEEK: velCmd <= dirNegQ ? -$signed({1'b0, srchVelQ})
                                                       : $signed({1'b0, srchVelQ}); // R3 R2
                    ST_BACK, ST_REENTER, ST_CROSS:
                        velCmd <= dirNegQ ? -$signed({1'b0, calVelQ}) : $signed({1'b0, calVelQ}); // R4
                    default: begin
                        if ((lStopLQ && sw.limL && manVelQ[VW-1]) ||
                            (lStopRQ && sw.limR && !manVelQ[VW-1] && manVelQ != '0)) begin
                            velCmd <= '0;
                        end else begin
                            velCmd <= manVelQ;
                        end
                    end
                endcase
            end
        end
    end

    // load sample and stall latch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            loadQ    <= '0;
            stalledQ <= 1'b0;
        end else begin
            loadQ <= loadIn; // R16
            if (stallNow) begin
                stalledQ <= 1'b1;
            end else if (clrStall) begin
                stalledQ <= 1'b0;
            end
        end
    end

    // sticky status, read-clear; a new event wins
    always_comb begin
        irqSet                 = '0;
        irqSet[`IRQ_DONE]      = hitAny && !stopReq && !stallNow;
        irqSet[`IRQ_STALL]     = stallNow;
        irqSet[`IRQ_BADMODE]   = startReq && stateQ == ST_IDLE && !planNew.ok;
        irqSet[`IRQ_ABORT]     = stopReq && stateQ != ST_IDLE;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStatQ <= '0;
            irq      <= 1'b0;
        end else begin
            if (doRead && s_axi_araddr == `OFF_IRQ_STAT) begin
                irqStatQ <= irqSet;
            end else begin
                irqStatQ <= irqStatQ | irqSet;
            end
            irq <= |(irqStatQ & irqMaskQ);
        end
    end
endmodule // stepper_ref_search
`default_nettype wire

/* File: axis_model.sv */
// behavioural axis: a microstep every fourth cycle while moving, switches from position
// assumes a circular 400-microstep stage so limit-free modes cannot run away
`timescale 1ns/1ps
`default_nettype none
module axis_model (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic signed [23:0] velCmd,
    input  wire logic               homeInv,
    output var stepper_ref_pkg::step_s stepIn,
    output var stepper_ref_pkg::sw_s   swPins
);
    import stepper_ref_pkg::*;
    int pos;
    logic [1:0] div;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 0;
            div <= 2'h0;
            stepIn <= '0;
        end else begin
            div <= div + 2'h1;
            stepIn <= '{step: velCmd != 0 && div == 2'h0, dirNeg: velCmd < 0};
            if (stepIn.step)
                pos <= stepIn.dirNeg ? (pos == -200 ? 199 : pos - 1) : (pos == 199 ? -200 : pos + 1);
        end
    end
    // switches have width so a centre search finds two edges
    assign swPins = '{home: (pos >= 10 && pos <= 20) ^ homeInv, limR: pos >= 50 && pos <= 60,
                      limL: pos <= -50 && pos >= -60};
endmodule // axis_model
`default_nettype wire

/* File: ref_search_properties.sv */
// bus handshake and homing speed checks
// assumes default homing velocities
`timescale 1ns/1ps
`default_nettype none
module ref_search_properties #(
    parameter int VW = 24
) (
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic                 homeBusy,
    input wire logic signed [VW-1:0] velCmd
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready held");
    a_ar_answer: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_home_speed: assert property (homeBusy && velCmd != 0 |-> velCmd inside {24'sh1000, -24'sh1000, 24'sh100, -24'sh100})
        else $error("homing speed off");
endmodule // ref_search_properties
bind stepper_ref_search ref_search_properties #(.VW(VW)) ref_search_properties_inst (.*);
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the reference search block
// assumes axis_model as motion generator and switches
`include "stepper_ref_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import stepper_ref_pkg::*;
    logic sys_clk = 0, rst_n = 0, homeInv = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, homeBusy, irq;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [9:0] loadIn = 10'h3ff;
    logic signed [23:0] velCmd;
    sw_s swPins;
    step_s stepIn;
    int n_mismatch = 0, checks = 0;
    logic [7:0] modes[16] = '{1, 65, 2, 66, 3, 67, 4, 68, 5, 129, 6, 130, 7, 131, 8, 132};
    stepper_ref_search stepper_ref_search_inst (.*);
    axis_model axis_model_inst (.*);
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'b111};
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        {d, r} = {s_axi_rdata, s_axi_rresp};
    endtask
    task automatic t_regs;
        rd(`OFF_MODE);
        chk(d, `RST_MODE, "mode reset");
        rd(`OFF_STATUS);
        chk(d[15:2], {`MODE_OPCODE, 6'h01}, "opcode and idle");
        wr(8'h34, 32'h0);
        chk(r, `RESP_SLVERR, "unmapped write");
        wr(`OFF_MODE, 32'h9);
        wr(`OFF_CTRL, 32'h1);
        rd(`OFF_IRQ_STAT);
        chk(d[3:0], 4'h4, "bad mode");
        $display("test regs done");
    endtask
    task automatic t_home(input logic [7:0] m);
        int e;
        homeInv <= m[7];
        wr(`OFF_IRQ_MASK, 32'h1);
        wr(`OFF_MODE, m);
        wr(`OFF_CTRL, 32'h19);
        do @(posedge sys_clk); while (irq !== 1'b1);
        rd(`OFF_STATUS);
        chk(d[2:0], 3'h5, "done and idle");
        rd(`OFF_IRQ_STAT);
        chk(d[3:0], 4'h1, "done event");
        if (m == 2 || m == 3) begin
            rd(`OFF_DIST);
            e = (m == 2) ? 100 : 105;
            chk(32'(d >= e - 3 && d <= e + 3), 1, "distance");
        end
        @(posedge sys_clk);
        chk(irq, 0, "irq cleared");
        $display("test home mode %0d done", m);
    endtask
    task automatic t_stall;
        wr(`OFF_IRQ_MASK, 32'h0);
        wr(`OFF_STALL_VEL, 32'h2000);
        wr(`OFF_CTRL, 32'h4);
        loadIn <= 10'h0;
        wr(`OFF_MAN_VEL, 32'h1000);
        repeat (8) @(posedge sys_clk);
        chk(velCmd, 32'h1000, "slow run kept");
        wr(`OFF_STALL_VEL, 32'h800);
        repeat (8) @(posedge sys_clk);
        chk(velCmd, 0, "stall stop");
        chk(irq, 0, "masked");
        rd(`OFF_IRQ_STAT);
        chk(d[1], 1, "stall event");
        rd(`OFF_LOAD);
        chk(d, 0, "load");
        $display("test stall done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1;
        t_regs;
        foreach (modes[i]) t_home(modes[i]);
        t_stall;
        results;
    end
    // far beyond the expected run
    initial begin
        #800000;
        n_mismatch++;
        results;
    end
endmodule // testbench
`default_nettype wire
